// File: core/svw_delay.sv
`timescale 1ns/1ns
`default_nettype none
`include "svw_params.svh"

module svw_delay (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic start,
	input wire logic stop,
	input wire logic [15:0] len,
	output logic busy,
	output logic done
);
	logic [15:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				cnt_q <= len;
				busy <= 1'b1;
			end else if (stop) begin
				busy <= 1'b0;
			end else if (busy && tick) begin
				// A length of zero still lasts one tick
				if (cnt_q <= `SVW_DLY_LAST) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - `SVW_DLY_LAST;
				end
			end
		end
	end

	AST_DLY_RUN: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && start) |=> busy && !done)
		else $error("delay timer did not start");

endmodule

`default_nettype wire

// File: core/svw_params.svh
`ifndef SVW_PARAMS_SVH
`define SVW_PARAMS_SVH

// Register byte offsets
`define SVW_REG_PERIOD 8'h00
`define SVW_REG_RSTDLY 8'h04
`define SVW_REG_VIEW 8'h08
`define SVW_REG_IRQ_STAT 8'h0c
`define SVW_REG_IRQ_CLR 8'h10
`define SVW_REG_IRQ_EN 8'h14

// Reset values
`define SVW_PERIOD_RST 16'h0010
`define SVW_RSTDLY_RST 16'h0014
`define SVW_IRQ_EN_RST 3'h0

// Upper period is this multiple of the lower period
`define SVW_UPPER_RATIO 21'h00001f

// Timing: one watchdog tick is 1 ms
`define SVW_CLK_NS 20
`define SVW_TICK_NS 1000000

// Synchronised pins at reset: undervoltage and disable assumed, so no false recovery
`define SVW_PINS_RST 4'hc

// Last tick of the delay timer
`define SVW_DLY_LAST 16'h0001

`endif

// File: core/svw_pkg.sv
`default_nettype none

package svw_pkg;

	typedef enum logic [3:0] {
		ST_UV = 4'b0001,
		ST_PORDLY = 4'b0010,
		ST_WATCH = 4'b0100,
		ST_FAULT = 4'b1000
	} svw_state_type;

	// Synchronised pin levels
	typedef struct packed {
		logic uv;
		logic dis;
		logic timeout_mode;
		logic kick;
	} svw_pins_type;

	// Sticky interrupt events, bit 2 down to bit 0
	typedef struct packed {
		logic wd_fault;
		logic rst_release;
		logic uv_assert;
	} svw_event_type;

	// Live state as software reads it
	typedef struct packed {
		svw_pins_type pins;
		logic fault_n;
		logic rst_n;
		logic armed;
		svw_state_type state;
	} svw_view_type;

endpackage

`default_nettype wire

// File: core/svw_supervisor.sv
// Contract
// - System reset is driven low whenever the output monitor reports undervoltage.
// - When the output recovers, the delay timer starts and reset releases when it expires.
// - The reset delay length is its own setting, apart from the watchdog periods.
// - A level input disables the watchdog, and the reset delay timer also times the fault pulse.
// - A dedicated mode input chooses timeout mode or window mode.
// - In timeout mode any kick level change clears the timer, and no change for the upper period faults.
// - In window mode only falling kick edges count as kicks.
// - In window mode a kick interval shorter than lower or longer than upper faults.
// - A fault drives the fault output low and starts the delay timer, held low while it runs.
// - The fault output returns high when the timer expires or when undervoltage resets the system.
// - Upper and lower watchdog periods both derive from one period setting.
// - Mode input low selects window mode, high selects timeout mode.
// - With the disable input high the watchdog is idle and the fault output stays high.
// - During a fault pulse kicks are ignored, and timing restarts once the fault output is high.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "svw_params.svh"

module svw_supervisor #(
	parameter int unsigned TICK_CYC = `SVW_TICK_NS / `SVW_CLK_NS
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic VOUT_LOW,
	input wire logic WATCHDOG_KICK_IN,
	input wire logic WATCHDOG_DISABLE_IN,
	input wire logic WATCHDOG_MODE_TIMEOUT,
	output logic SYS_RESET_N,
	output logic WATCHDOG_FAULT_N,
	output logic IRQ
);
	import svw_pkg::*;

	svw_pins_type pins_raw, pins_s;
	svw_state_type state_q;
	svw_event_type irq_stat_q, irq_evt, irq_clr;
	svw_view_type view;
	logic [2:0] irq_en_q;
	logic [31:0] pre_q, dat_q, rd_val;
	logic [15:0] period_q, rstdly_q;
	logic [20:0] wd_lower, wd_upper, wd_cnt_q;
	logic [7:0] adr_w;
	logic tick, kick_q, kick_fall, kick_any, kick_valid, armed_q, wd_trip;
	logic rst_q, fault_q, irq_q, dly_start, dly_stop, dly_busy, dly_done;
	logic wb_req, wb_wr, ack_q;

	// All four pins come from outside the clock domain
	assign pins_raw = '{VOUT_LOW, WATCHDOG_DISABLE_IN, WATCHDOG_MODE_TIMEOUT, WATCHDOG_KICK_IN};

	svw_sync #(.WIDTH($bits(svw_pins_type)), .RST_VAL(`SVW_PINS_RST)) u_sync (
		.clk(MCLK), .rst_n(RST_N), .ce(CE), .din(pins_raw), .dout(pins_s)
	);

	// Millisecond tick that every period counts in
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pre_q <= '0;
		end else if (CE) begin
			if (tick) begin
				pre_q <= '0;
			end else begin
				pre_q <= pre_q + 32'h1;
			end
		end
	end

	assign tick = CE && (pre_q == 32'(TICK_CYC - 1));

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			kick_q <= 1'b0;
		end else if (CE) begin
			kick_q <= pins_s.kick;
		end
	end

	assign kick_fall = kick_q && !pins_s.kick;
	assign kick_any = kick_q ^ pins_s.kick;
	// Low selects window mode, high timeout mode
	assign kick_valid = pins_s.timeout_mode ? kick_any : kick_fall;

	assign wd_lower = 21'(period_q);
	assign wd_upper = 21'(period_q) * `SVW_UPPER_RATIO;

	// The first window kick after a restart only opens the window
	assign wd_trip = !pins_s.dis && ((wd_cnt_q >= wd_upper) ||
		(!pins_s.timeout_mode && kick_fall && armed_q && (wd_cnt_q < wd_lower)));

	// Watchdog interval counter
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			wd_cnt_q <= '0;
			armed_q <= 1'b0;
		end else if (CE) begin
			if (state_q != ST_WATCH || pins_s.dis || wd_trip) begin
				wd_cnt_q <= '0;
				armed_q <= 1'b0;
			end else if (kick_valid) begin
				wd_cnt_q <= '0;
				armed_q <= 1'b1;
			end else if (tick) begin
				wd_cnt_q <= wd_cnt_q + 21'h1;
			end
		end
	end

	// Shared delay timer: power-on release and fault pulse
	assign dly_start = CE && !pins_s.uv && ((state_q == ST_UV) ||
		(state_q == ST_WATCH && wd_trip));
	assign dly_stop = CE && (pins_s.uv || (state_q == ST_FAULT && pins_s.dis));

	svw_delay u_delay (
		.clk(MCLK), .rst_n(RST_N), .ce(CE), .tick(tick), .start(dly_start), .stop(dly_stop),
		.len(rstdly_q), .busy(dly_busy), .done(dly_done)
	);

	// Supervisor state and both outputs
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_UV;
			rst_q <= 1'b0;
			fault_q <= 1'b1;
		end else if (CE) begin
			case (state_q)
				ST_UV: begin
					rst_q <= 1'b0;
					fault_q <= 1'b1;
					if (!pins_s.uv) begin
						state_q <= ST_PORDLY;
					end
				end
				ST_PORDLY: begin
					if (pins_s.uv) begin
						state_q <= ST_UV;
					end else if (dly_done) begin
						state_q <= ST_WATCH;
						rst_q <= 1'b1;
					end
				end
				ST_WATCH: begin
					if (pins_s.uv) begin
						state_q <= ST_UV;
						rst_q <= 1'b0;
					end else if (wd_trip) begin
						state_q <= ST_FAULT;
						fault_q <= 1'b0;
					end
				end
				ST_FAULT: begin
					if (pins_s.uv) begin
						state_q <= ST_UV;
						rst_q <= 1'b0;
						fault_q <= 1'b1;
					end else if (dly_done || pins_s.dis) begin
						state_q <= ST_WATCH;
						fault_q <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_UV;
					rst_q <= 1'b0;
					fault_q <= 1'b1;
				end
			endcase
		end
	end

	assign SYS_RESET_N = rst_q;
	assign WATCHDOG_FAULT_N = fault_q;

	// Interrupt events: watchdog fault, reset release, undervoltage
	assign irq_evt = '{dly_start && state_q == ST_WATCH,
		CE && state_q == ST_PORDLY && !pins_s.uv && dly_done,
		CE && pins_s.uv && state_q != ST_UV};

	assign wb_req = WB_CYC_I && WB_STB_I;
	// Writes land on the edge where the master sees ack
	assign wb_wr = CE && wb_req && ack_q && WB_WE_I;
	assign adr_w = {WB_ADR_I[7:2], 2'b00};
	assign irq_clr = (wb_wr && adr_w == `SVW_REG_IRQ_CLR && WB_SEL_I[0]) ?
		svw_event_type'(WB_DAT_I[2:0]) : svw_event_type'(3'h0);

	// A new event beats a clear in the same cycle
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_stat_q <= '0;
			irq_q <= 1'b0;
		end else if (CE) begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	assign IRQ = irq_q;

	// Software settings; reset delay and watchdog period are independent
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			period_q <= `SVW_PERIOD_RST;
			rstdly_q <= `SVW_RSTDLY_RST;
			irq_en_q <= `SVW_IRQ_EN_RST;
		end else if (wb_wr) begin
			if (adr_w == `SVW_REG_PERIOD) begin
				if (WB_SEL_I[0]) begin
					period_q[7:0] <= WB_DAT_I[7:0];
				end
				if (WB_SEL_I[1]) begin
					period_q[15:8] <= WB_DAT_I[15:8];
				end
			end else if (adr_w == `SVW_REG_RSTDLY) begin
				if (WB_SEL_I[0]) begin
					rstdly_q[7:0] <= WB_DAT_I[7:0];
				end
				if (WB_SEL_I[1]) begin
					rstdly_q[15:8] <= WB_DAT_I[15:8];
				end
			end else if (adr_w == `SVW_REG_IRQ_EN) begin
				if (WB_SEL_I[0]) begin
					irq_en_q <= WB_DAT_I[2:0];
				end
			end
		end
	end

	assign view = '{pins_s, fault_q, rst_q, armed_q, state_q};

	always_comb begin
		if (adr_w == `SVW_REG_PERIOD) begin
			rd_val = 32'(period_q);
		end else if (adr_w == `SVW_REG_RSTDLY) begin
			rd_val = 32'(rstdly_q);
		end else if (adr_w == `SVW_REG_VIEW) begin
			rd_val = 32'(view);
		end else if (adr_w == `SVW_REG_IRQ_STAT) begin
			rd_val = 32'(irq_stat_q);
		end else if (adr_w == `SVW_REG_IRQ_EN) begin
			rd_val = 32'(irq_en_q);
		end else begin
			rd_val = '0;
		end
	end

	// One wait state; unmapped addresses still answer, reading zero
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else if (CE) begin
			ack_q <= wb_req && !ack_q;
			if (wb_req && !ack_q) begin
				dat_q <= rd_val;
			end
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_uv_seen;
		CE && pins_s.uv;
	endsequence

	sequence s_recover;
		CE && state_q == ST_UV && !pins_s.uv;
	endsequence

	sequence s_watch_live;
		CE && state_q == ST_WATCH && !pins_s.uv && !pins_s.dis;
	endsequence

	AST_UV_RESET: assert property (s_uv_seen |=> !SYS_RESET_N)
		else $error("reset not low during undervoltage");

	AST_POR_START: assert property (s_recover |=> dly_busy && !SYS_RESET_N)
		else $error("recovery did not start the delay");

	AST_POR_RELEASE: assert property ($rose(SYS_RESET_N) |-> $past(dly_done))
		else $error("reset released before delay expiry");

	AST_TIMEOUT: assert property ((s_watch_live ##0 wd_cnt_q >= wd_upper)
		|=> !WATCHDOG_FAULT_N && dly_busy)
		else $error("missed timeout fault");

	AST_TIMEOUT_KICK: assert property ((s_watch_live ##0 pins_s.timeout_mode
		##0 kick_any && !wd_trip) |=> wd_cnt_q == '0)
		else $error("level change did not clear counter");

	AST_WIN_RISE_IGNORED: assert property ((s_watch_live ##0 !pins_s.timeout_mode
		##0 !kick_q && pins_s.kick && !tick && !wd_trip) |=> wd_cnt_q == $past(wd_cnt_q))
		else $error("rising kick counted in window mode");

	AST_WIN_EARLY: assert property ((s_watch_live ##0 !pins_s.timeout_mode ##0
		kick_fall && armed_q && wd_cnt_q < wd_lower) |=> !WATCHDOG_FAULT_N)
		else $error("early kick not faulted");

	AST_FAULT_TIMER: assert property ($fell(WATCHDOG_FAULT_N) |-> dly_busy)
		else $error("fault without delay timer");

	AST_FAULT_END: assert property ($rose(WATCHDOG_FAULT_N) |->
		$past(dly_done || pins_s.uv || pins_s.dis))
		else $error("fault released without cause");

	AST_DIS_HIGH: assert property ((CE && pins_s.dis) |=> WATCHDOG_FAULT_N)
		else $error("fault low while disabled");

	AST_FAULT_NO_COUNT: assert property (state_q == ST_FAULT |->
		wd_cnt_q == '0 && !armed_q)
		else $error("watchdog timing during fault pulse");

endmodule

`default_nettype wire

// File: core/svw_sync.sv
`timescale 1ns/1ns
`default_nettype none

module svw_sync #(
	parameter int WIDTH = 4,
	// Safe level of each pin, so that no false change follows reset
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			dout <= RST_VAL;
		end else if (ce) begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// A bit follows only once two stages agree, so a single glitch never passes
			dout <= (s3_q & ~(s2_q ^ s3_q)) | (dout & (s2_q ^ s3_q));
		end
	end

	AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (!rst_n)
		((dout ^ $past(dout)) & $past(s2_q ^ s3_q)) == '0)
		else $error("synchronised bit changed while stages disagreed");

endmodule

`default_nettype wire

// File: tb/svw_kick_model.sv
`timescale 1ns/1ns
`default_nettype none

module svw_kick_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [7:0] gap,
	output logic watchdog_kick_in
);
	logic [7:0] cnt_q;

	// Falling edge every gap cycles, rising edge half way, so both levels last long enough
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			watchdog_kick_in <= 1'b1;
		end else if (!run || cnt_q >= gap - 8'h01) begin
			cnt_q <= 8'h00;
			if (run) begin
				watchdog_kick_in <= 1'b0;
			end
		end else begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q == (gap >> 1) - 8'h01) begin
				watchdog_kick_in <= 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// File: tb/test_svw_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
`include "svw_params.svh"

module test_svw_supervisor;
	localparam int TK = 4;
	logic mclk, rst_n, cyc, stb, we, vlow, dis, tmode, run, kick, srst_n, fault_n, irq, ack;
	logic [7:0] adr, gap;
	logic [31:0] wdat, rdat, q;
	int miscompares, num_checks, n;

	svw_supervisor #(.TICK_CYC(TK)) dut_u (
		.MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .VOUT_LOW(vlow), .WATCHDOG_KICK_IN(kick),
		.WATCHDOG_DISABLE_IN(dis), .WATCHDOG_MODE_TIMEOUT(tmode),
		.SYS_RESET_N(srst_n), .WATCHDOG_FAULT_N(fault_n), .IRQ(irq)
	);

	svw_kick_model kick_u (.clk(mclk), .rst_n(rst_n), .run(run), .gap(gap),
		.watchdog_kick_in(kick));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task close_out;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task fail(input string nm);
		miscompares++;
		$display("ERROR %s expected response seen none", nm);
		close_out;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk_rng(input string nm, input int lo, input int hi, input int g);
		num_checks++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// Classic single cycle; the ack is sampled at the edge where the flop sees it
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		if (i >= 20)
			fail("bus ack");
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, q & m);
	endtask

	task wait_for(input logic rs, input logic v, input int max);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while ((rs ? srst_n : fault_n) !== v && n < max);
		if (n >= max)
			fail(rs ? "reset level" : "fault level");
		@(posedge mclk);
	endtask

	task quiet(input int c);
		int low;
		low = 0;
		repeat (c) begin
			@(negedge mclk);
			if (fault_n !== 1'b1)
				low++;
		end
		chk_rng("fault low cycles", 0, 0, low);
		@(posedge mclk);
	endtask

	initial begin
		miscompares = 0;
		num_checks = 0;
		rst_n = 1'b0;
		{cyc, stb, we, run} = 4'h0;
		adr = 8'h00;
		wdat = 32'h0;
		vlow = 1'b1;
		dis = 1'b1;
		tmode = 1'b1;
		gap = 8'd40;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		chk("reset during init", 32'h1, {30'h0, srst_n, fault_n});
		chk("irq during init", 32'h0, {31'h0, irq});
		@(posedge mclk);
		rst_n <= 1'b1;
		rd(`SVW_REG_PERIOD, 32'hffff, {16'h0, `SVW_PERIOD_RST}, "period");
		rd(`SVW_REG_RSTDLY, 32'hffff, {16'h0, `SVW_RSTDLY_RST}, "rstdly");
		rd(`SVW_REG_IRQ_EN, 32'h7, 32'h0, "irq_en");
		rd(8'h1c, 32'hffffffff, 32'h0, "unmapped");
		wb(1'b1, `SVW_REG_PERIOD, 32'h2);
		wb(1'b1, `SVW_REG_RSTDLY, 32'h3);
		wb(1'b1, `SVW_REG_IRQ_EN, 32'h7);
		rd(`SVW_REG_PERIOD, 32'hffff, 32'h2, "period back");
		rd(`SVW_REG_IRQ_EN, 32'h7, 32'h7, "irq_en back");
		wb(1'b1, `SVW_REG_IRQ_CLR, 32'h7);
		repeat (10) @(posedge mclk);
		chk("reset under uv", 32'h0, {31'h0, srst_n});
		// Reset delay of 3 ticks, one tick of slack plus the input synchroniser
		vlow <= 1'b0;
		wait_for(1'b1, 1'b1, 60);
		chk_rng("reset delay", 2 * TK, 3 * TK + 8, n);
		rd(`SVW_REG_IRQ_STAT, 32'h2, 32'h2, "release event");
		chk("irq raised", 32'h1, {31'h0, irq});
		wb(1'b1, `SVW_REG_IRQ_EN, 32'h0);
		repeat (2) @(posedge mclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wb(1'b1, `SVW_REG_IRQ_CLR, 32'h7);
		wb(1'b1, `SVW_REG_IRQ_EN, 32'h7);
		repeat (2) @(posedge mclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(`SVW_REG_VIEW, 32'h7ff, 32'h3e4, "view");
		quiet(300);
		// Timeout mode, upper period is 62 ticks of 4 cycles
		dis <= 1'b0;
		run <= 1'b1;
		quiet(600);
		run <= 1'b0;
		wait_for(1'b0, 1'b0, 300);
		chk_rng("timeout fault", 31 * 2 * TK - 48, 31 * 2 * TK + 12, n);
		wait_for(1'b0, 1'b1, 40);
		chk_rng("fault pulse", 2 * TK, 3 * TK + 2, n);
		rd(`SVW_REG_IRQ_STAT, 32'h4, 32'h4, "fault event");
		wb(1'b1, `SVW_REG_IRQ_CLR, 32'h7);
		// Window mode, kicks inside the window keep it quiet
		tmode <= 1'b0;
		gap <= 8'd20;
		run <= 1'b1;
		quiet(500);
		gap <= 8'd4;
		wait_for(1'b0, 1'b0, 60);
		// Kicks keep coming during the pulse and must not stretch it
		wait_for(1'b0, 1'b1, 40);
		chk_rng("window fault pulse", 2 * TK, 3 * TK + 2, n);
		wb(1'b1, `SVW_REG_RSTDLY, 32'h8);
		wait_for(1'b0, 1'b0, 60);
		run <= 1'b0;
		vlow <= 1'b1;
		wait_for(1'b0, 1'b1, 10);
		chk("reset on uv", 32'h0, {31'h0, srst_n});
		@(posedge mclk);
		vlow <= 1'b0;
		wait_for(1'b1, 1'b1, 60);
		chk_rng("long reset delay", 7 * TK, 8 * TK + 8, n);
		close_out;
	end
endmodule

`default_nettype wire
